// [gpio_irq_defines.vh]
// Register offsets, reset values and sizes of the pin interrupt block
`ifndef GPIO_IRQ_DEFINES_VH
`define GPIO_IRQ_DEFINES_VH

// ==========================================================================
// Geometry
`define PORT_COUNT 2
`define PORT_WIDTH 32
`define PERIPH_FUNCS 4
`define IRQ_GROUP 8
`define IRQS_PER_PORT 4
`define ADDR_WIDTH 9
`define PORT_SEL_BIT 8
`define PORT_STRIDE 9'h100

// ==========================================================================
// Register base offsets inside one port (word index = offset[7:4])
`define OFS_PIN_CONTROL_ENABLE 8'h00
`define OFS_PERIPH_SELECT_LOW 8'h10
`define OFS_PERIPH_SELECT_HIGH 8'h20
`define OFS_OUTPUT_DRIVER_ENABLE 8'h40
`define OFS_OUTPUT_VALUE 8'h50
`define OFS_PIN_VALUE 8'h60
`define OFS_PULL_UP_ENABLE 8'h70
`define OFS_PIN_INTERRUPT_ENABLE 8'h90
`define OFS_IRQ_MODE_LOW 8'hA0
`define OFS_IRQ_MODE_HIGH 8'hB0
`define OFS_GLITCH_FILTER_ENABLE 8'hC0
`define OFS_PIN_INTERRUPT_FLAGS 8'hD0
`define OFS_PIN_INTERRUPT_FLAGS_CLR 8'hD8

// Sub-address within a register group, taken from offset[3:2]
`define ACC_WRITE 2'h0
`define ACC_SET 2'h1
`define ACC_CLEAR 2'h2
`define ACC_TOGGLE 2'h3

// ==========================================================================
// Interrupt modes {high bit, low bit}
`define MODE_CHANGE 2'h0
`define MODE_RISING 2'h1
`define MODE_FALLING 2'h2

// ==========================================================================
// Reset values
`define RST_ZERO 32'h00000000
`define RST_P0_PIN_CONTROL 32'h0FFFFFFF
`define RST_P0_FLAGS 32'h0FFFFFFF
`define RST_P1_PIN_CONTROL 32'h00000FFF
`define RST_P1_FLAGS 32'h00000FFF

`endif

// [gpio_glitch_filter.v]
// Per-pin glitch filter with bypass, one port wide
`timescale 1ns/1ns
module gpio_glitch_filter (
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// Pins and control
	input wire [31:0] pin_in,
	input wire [31:0] filter_en,
	output reg [31:0] level_q
);
	reg [31:0] prev_q;
	integer i;

	// ======================================================================
	// Filter
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prev_q <= 32'h00000000;
			level_q <= 32'h00000000;
		end else begin
			prev_q <= pin_in;
			for (i = 0; i < 32; i = i + 1) begin
				if (!filter_en[i]) begin
					level_q[i] <= pin_in[i];
				end else if (pin_in[i] == prev_q[i]) begin
					// Level seen on two edges in a row before it is passed
					level_q[i] <= pin_in[i];
				end
			end
		end
	end
endmodule // gpio_glitch_filter

// [gpio_edge_detect.v]
// Per-pin change/rising/falling detection, one port wide
`timescale 1ns/1ns
`include "gpio_irq_defines.vh"
module gpio_edge_detect (
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// Filtered level and mode
	input wire [31:0] level,
	input wire [31:0] mode_low,
	input wire [31:0] mode_high,
	output reg [31:0] event_hit
);
	reg [31:0] last_q;
	integer i;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			last_q <= 32'h00000000;
		end else begin
			last_q <= level;
		end
	end

	// ======================================================================
	// Mode decode; the reserved code raises nothing
	always @* begin
		event_hit = 32'h00000000;
		for (i = 0; i < 32; i = i + 1) begin
			case ({mode_high[i], mode_low[i]})
				`MODE_CHANGE: event_hit[i] = level[i] ^ last_q[i];
				`MODE_RISING: event_hit[i] = level[i] & ~last_q[i];
				`MODE_FALLING: event_hit[i] = ~level[i] & last_q[i];
				default: event_hit[i] = 1'b0;
			endcase
		end
	end
endmodule // gpio_edge_detect

// [gpio_pin_interrupt_filter.v]
// Two-port pin controller: registers, glitch filters, edge flags, interrupt lines
//
// Overview of operation
// - Mode code 00 flags any change, 01 a rising edge, 10 a falling edge, 11 nothing.
// - A pin's input goes through the glitch filter when its filter enable is 1, else bypasses it.
// - Filter enable has write, set, clear and toggle addresses at 0xC0, 0xC4, 0xC8, 0xCC.
// - A detected condition sets the pin's interrupt flag to 1 when its interrupt enable bit is 1.
// - A flag stays 1 until cleared, so 0 means no condition was seen on an enabled pin since reset or clear.
// - Flags are read at 0xD0 and cleared by writing ones at 0xD8, with no plain write.
// - There is one interrupt line per group of eight pins, so lines scale with pins.
// - Registers reset to zero except pin control enable and flags, per port.
// - Two ports are built, each pin choosing among four peripheral functions.
// - All registers run on the single module clock.
// - A pin raises interrupts only while its interrupt enable bit is 1.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns
`include "gpio_irq_defines.vh"
module gpio_pin_interrupt_filter (
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// Register port
	input wire [8:0] addr,
	input wire [31:0] wr_data,
	input wire wr_strobe,
	input wire rd_strobe,
	output reg [31:0] rd_data,
	// Pins, port 0
	input wire [31:0] pin_in_p0,
	output reg [31:0] pin_out_p0,
	output reg [31:0] pin_oe_p0,
	output reg [31:0] pull_up_p0,
	output reg [31:0] pin_control_p0,
	output reg [63:0] periph_select_p0,
	// Pins, port 1
	input wire [31:0] pin_in_p1,
	output reg [31:0] pin_out_p1,
	output reg [31:0] pin_oe_p1,
	output reg [31:0] pull_up_p1,
	output reg [31:0] pin_control_p1,
	output reg [63:0] periph_select_p1,
	// Interrupt lines, four per port
	output reg [7:0] irq
);
	// ======================================================================
	// Storage: one word per {port, register group}
	// Flags and pin levels live apart: they are not plain read/write words
	reg [31:0] rf_q [0:31];
	reg [31:0] flags_q [0:1];
	reg [31:0] pin_level_q [0:1];
	wire [31:0] level_p0;
	wire [31:0] level_p1;
	wire [31:0] hit_p0;
	wire [31:0] hit_p1;
	wire port_sel;
	wire [3:0] grp;
	wire [1:0] acc;
	wire [4:0] idx;
	reg [31:0] rd_d;
	integer i;

	assign port_sel = addr[`PORT_SEL_BIT];
	assign grp = addr[7:4];
	assign acc = addr[3:2];
	assign idx = {port_sel, grp};

	// ======================================================================
	// Helpers
	function [4:0] rix;
		input p;
		input [7:0] ofs;
		begin
			rix = {p, ofs[7:4]};
		end
	endfunction

	function [31:0] apply_access;
		input [31:0] old;
		input [31:0] data;
		input [1:0] kind;
		begin
			case (kind)
				`ACC_WRITE: apply_access = data;
				`ACC_SET: apply_access = old | data;
				`ACC_CLEAR: apply_access = old & ~data;
				`ACC_TOGGLE: apply_access = old ^ data;
				default: apply_access = old;
			endcase
		end
	endfunction

	function is_rw_group;
		input [3:0] g;
		begin
			case ({g, 4'h0})
				`OFS_PIN_CONTROL_ENABLE,
				`OFS_PERIPH_SELECT_LOW,
				`OFS_PERIPH_SELECT_HIGH,
				`OFS_OUTPUT_DRIVER_ENABLE,
				`OFS_OUTPUT_VALUE,
				`OFS_PULL_UP_ENABLE,
				`OFS_PIN_INTERRUPT_ENABLE,
				`OFS_IRQ_MODE_LOW,
				`OFS_IRQ_MODE_HIGH,
				`OFS_GLITCH_FILTER_ENABLE: is_rw_group = 1'b1;
				default: is_rw_group = 1'b0;
			endcase
		end
	endfunction

	// Interleave the two select bits into one 2-bit field per pin
	function [63:0] pack_select;
		input [31:0] low;
		input [31:0] high;
		integer k;
		begin
			pack_select = 64'h0000000000000000;
			for (k = 0; k < 32; k = k + 1) begin
				pack_select[2*k] = low[k];
				pack_select[2*k+1] = high[k];
			end
		end
	endfunction

	function [3:0] group_irq;
		input [31:0] flags;
		input [31:0] enable;
		reg [31:0] live;
		integer k;
		begin
			live = flags & enable;
			for (k = 0; k < `IRQS_PER_PORT; k = k + 1) begin
				group_irq[k] = |live[k*`IRQ_GROUP +: `IRQ_GROUP];
			end
		end
	endfunction

	// Write-one-to-clear mask for one port's flags
	function [31:0] clear_mask;
		input p;
		input [8:0] a;
		input we;
		input [31:0] data;
		begin
			if (we && a[`PORT_SEL_BIT] == p && a[7:0] == `OFS_PIN_INTERRUPT_FLAGS_CLR) begin
				clear_mask = data;
			end else begin
				clear_mask = 32'h00000000;
			end
		end
	endfunction

	// Set beats clear, so an edge landing on the clear cycle is not lost
	function [31:0] flag_next;
		input [31:0] old;
		input [31:0] clr;
		input [31:0] hit;
		input [31:0] en;
		begin
			flag_next = (old & ~clr) | (hit & en);
		end
	endfunction

	// ======================================================================
	// Per-port filtering and detection
	// Filter enable acts live; toggling it under an enabled pin can fake an edge
	gpio_glitch_filter u_filter_p0 (
		.clk(clk),
		.reset_n(reset_n),
		.pin_in(pin_in_p0),
		.filter_en(rf_q[rix(1'b0, `OFS_GLITCH_FILTER_ENABLE)]),
		.level_q(level_p0)
	);

	gpio_glitch_filter u_filter_p1 (
		.clk(clk),
		.reset_n(reset_n),
		.pin_in(pin_in_p1),
		.filter_en(rf_q[rix(1'b1, `OFS_GLITCH_FILTER_ENABLE)]),
		.level_q(level_p1)
	);

	gpio_edge_detect u_edge_p0 (
		.clk(clk),
		.reset_n(reset_n),
		.level(level_p0),
		.mode_low(rf_q[rix(1'b0, `OFS_IRQ_MODE_LOW)]),
		.mode_high(rf_q[rix(1'b0, `OFS_IRQ_MODE_HIGH)]),
		.event_hit(hit_p0)
	);

	gpio_edge_detect u_edge_p1 (
		.clk(clk),
		.reset_n(reset_n),
		.level(level_p1),
		.mode_low(rf_q[rix(1'b1, `OFS_IRQ_MODE_LOW)]),
		.mode_high(rf_q[rix(1'b1, `OFS_IRQ_MODE_HIGH)]),
		.event_hit(hit_p1)
	);

	// ======================================================================
	// Register file writes
	// Pin value, flags and unmapped words fall through and are ignored
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (i = 0; i < 32; i = i + 1) begin
				rf_q[i] <= `RST_ZERO;
			end
			rf_q[{1'b0, 4'h0}] <= `RST_P0_PIN_CONTROL;
			rf_q[{1'b1, 4'h0}] <= `RST_P1_PIN_CONTROL;
		end else if (wr_strobe && is_rw_group(grp)) begin
			// Same bits reached four ways: write, set, clear, toggle
			rf_q[idx] <= apply_access(rf_q[idx], wr_data, acc);
		end
	end

	// ======================================================================
	// Interrupt flags: a new event wins over a clear in the same cycle
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			flags_q[0] <= `RST_P0_FLAGS;
			flags_q[1] <= `RST_P1_FLAGS;
		end else begin
			flags_q[0] <= flag_next(flags_q[0], clear_mask(1'b0, addr, wr_strobe, wr_data),
				hit_p0, rf_q[rix(1'b0, `OFS_PIN_INTERRUPT_ENABLE)]);
			flags_q[1] <= flag_next(flags_q[1], clear_mask(1'b1, addr, wr_strobe, wr_data),
				hit_p1, rf_q[rix(1'b1, `OFS_PIN_INTERRUPT_ENABLE)]);
		end
	end

	// ======================================================================
	// Pin value seen by software, sampled raw each cycle
	// Unfiltered, so software may see glitches that never reach the flags
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_level_q[0] <= 32'h00000000;
			pin_level_q[1] <= 32'h00000000;
		end else begin
			pin_level_q[0] <= pin_in_p0;
			pin_level_q[1] <= pin_in_p1;
		end
	end

	// ======================================================================
	// Read path; set/clear/toggle addresses and unmapped words read zero
	always @* begin
		rd_d = 32'h00000000;
		if (acc == `ACC_WRITE && is_rw_group(grp)) begin
			rd_d = rf_q[idx];
		end else if (addr[7:0] == `OFS_PIN_VALUE) begin
			rd_d = pin_level_q[port_sel];
		end else if (addr[7:0] == `OFS_PIN_INTERRUPT_FLAGS) begin
			rd_d = flags_q[port_sel];
		end
	end

	// Idle read data is zero, so a stray sample shows nothing stale
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_data <= 32'h00000000;
		end else if (rd_strobe) begin
			rd_data <= rd_d;
		end else begin
			rd_data <= 32'h00000000;
		end
	end

	// ======================================================================
	// Registered pin controls and interrupt lines
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_out_p0 <= 32'h00000000;
			pin_oe_p0 <= 32'h00000000;
			pull_up_p0 <= 32'h00000000;
			pin_control_p0 <= `RST_P0_PIN_CONTROL;
			periph_select_p0 <= 64'h0000000000000000;
			pin_out_p1 <= 32'h00000000;
			pin_oe_p1 <= 32'h00000000;
			pull_up_p1 <= 32'h00000000;
			pin_control_p1 <= `RST_P1_PIN_CONTROL;
			periph_select_p1 <= 64'h0000000000000000;
			irq <= 8'h00;
		end else begin
			pin_out_p0 <= rf_q[rix(1'b0, `OFS_OUTPUT_VALUE)];
			pin_oe_p0 <= rf_q[rix(1'b0, `OFS_OUTPUT_DRIVER_ENABLE)];
			pull_up_p0 <= rf_q[rix(1'b0, `OFS_PULL_UP_ENABLE)];
			pin_control_p0 <= rf_q[rix(1'b0, `OFS_PIN_CONTROL_ENABLE)];
			periph_select_p0 <= pack_select(rf_q[rix(1'b0, `OFS_PERIPH_SELECT_LOW)],
				rf_q[rix(1'b0, `OFS_PERIPH_SELECT_HIGH)]);
			pin_out_p1 <= rf_q[rix(1'b1, `OFS_OUTPUT_VALUE)];
			pin_oe_p1 <= rf_q[rix(1'b1, `OFS_OUTPUT_DRIVER_ENABLE)];
			pull_up_p1 <= rf_q[rix(1'b1, `OFS_PULL_UP_ENABLE)];
			pin_control_p1 <= rf_q[rix(1'b1, `OFS_PIN_CONTROL_ENABLE)];
			periph_select_p1 <= pack_select(rf_q[rix(1'b1, `OFS_PERIPH_SELECT_LOW)],
				rf_q[rix(1'b1, `OFS_PERIPH_SELECT_HIGH)]);
			// Stale flags of disabled pins are masked off the lines
			irq <= {group_irq(flags_q[1], rf_q[rix(1'b1, `OFS_PIN_INTERRUPT_ENABLE)]),
				group_irq(flags_q[0], rf_q[rix(1'b0, `OFS_PIN_INTERRUPT_ENABLE)])};
		end
	end
endmodule // gpio_pin_interrupt_filter

// [gpio_irq_monitor.sv]
// Port assertions for the pin interrupt block
`timescale 1ns/1ns
// ==========
// Checker
module gpio_irq_monitor (
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// Register port
	input wire [8:0] addr,
	input wire [31:0] wr_data,
	input wire wr_strobe,
	input wire rd_strobe,
	input wire [31:0] rd_data,
	// Pins and lines
	input wire [31:0] pin_in_p0,
	input wire [31:0] pin_oe_p1,
	input wire [31:0] pin_control_p0,
	input wire [31:0] pin_control_p1,
	input wire [63:0] periph_select_p0,
	input wire [7:0] irq
);
	reg [3:0] calm_q;
	reg [31:0] pin_q;
	// Counts quiet cycles, so a clear is judged only with no event still in flight
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			calm_q <= 4'h0;
			pin_q <= 32'h0;
		end else begin
			pin_q <= pin_in_p0;
			calm_q <= (pin_in_p0 != pin_q) ? 4'h0 : (calm_q == 4'hF) ? calm_q : calm_q + 4'h1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_read_idle: assert property (!rd_strobe |=> rd_data == 32'h0)
		else $error("read data not idle");
	a_reset_values: assert property ($rose(reset_n) |->
		pin_control_p0 == 32'h0FFFFFFF && pin_control_p1 == 32'h00000FFF)
		else $error("pin control reset value wrong");
	a_reset_quiet: assert property ($rose(reset_n) |-> irq == 8'h00 && pin_oe_p1 == 32'h0)
		else $error("lines not quiet after reset");
	a_empty_reads: assert property (rd_strobe && (addr[3:2] != 2'h0 || addr[7:4] > 4'hD)
		|=> rd_data == 32'h0)
		else $error("empty address read nonzero");
	a_filter_rw: assert property (wr_strobe && addr == 9'h0C0 ##2 rd_strobe && addr == 9'h0C0
		|=> rd_data == $past(wr_data, 3))
		else $error("filter enable readback wrong");
	a_oe_lag: assert property (wr_strobe && addr == 9'h140
		|=> ##1 pin_oe_p1 == $past(wr_data, 2))
		else $error("driver enable output wrong");
	a_select_lag: assert property (wr_strobe && addr == 9'h010
		|=> ##1 periph_select_p0[0] == $past(wr_data[0], 2))
		else $error("select output wrong");
	a_clear_irq: assert property (wr_strobe && addr == 9'h0D8 && wr_data == 32'hFFFFFFFF
		&& calm_q > 4'h7 |=> ##1 irq[3:0] == 4'h0)
		else $error("line stays high after clear");
endmodule // gpio_irq_monitor
bind gpio_pin_interrupt_filter gpio_irq_monitor mon (.*);

// [pin_model.sv]
// External pin sources with one-cycle glitch injection
`timescale 1ns/1ns
// ==========
// Pins
module pin_model (
	// Clock
	input wire clk,
	// Wanted levels and glitch masks
	input wire [63:0] level,
	input wire [63:0] glitch,
	// Pins
	output reg [31:0] pin_p0,
	output reg [31:0] pin_p1
);
	initial {pin_p1, pin_p0} = 64'h0;
	// A glitch lasts one clock, the shortest pulse a sampled source can make
	always @(posedge clk) begin
		{pin_p1, pin_p0} <= level ^ glitch;
	end
endmodule // pin_model

// [testbench.sv]
// Self-checking bench for the pin interrupt block
`timescale 1ns/1ns
// ==========
// Bench
module testbench;
	reg clk;
	reg reset_n;
	reg [8:0] addr;
	reg [31:0] wr_data;
	reg wr_strobe;
	reg rd_strobe;
	wire [31:0] rd_data;
	wire [31:0] pin_p0;
	wire [31:0] pin_p1;
	wire [7:0] irq;
	wire [31:0] out_p0;
	wire [31:0] out_p1;
	wire [31:0] oe_p0;
	wire [31:0] oe_p1;
	wire [31:0] pu_p0;
	wire [31:0] pu_p1;
	wire [31:0] ctl_p0;
	wire [31:0] ctl_p1;
	wire [63:0] sel_p0;
	wire [63:0] sel_p1;
	reg [63:0] sx;
	reg [63:0] level;
	reg [63:0] glitch;
	reg [31:0] seed;
	reg [31:0] v;
	reg [31:0] r;
	reg [8:0] ba;
	integer err_total;
	integer n_tests;
	integer cyc;
	integer i;
	gpio_pin_interrupt_filter dut (.clk(clk), .reset_n(reset_n), .addr(addr),
		.wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
		.pin_in_p0(pin_p0), .pin_out_p0(out_p0), .pin_oe_p0(oe_p0), .pull_up_p0(pu_p0),
		.pin_control_p0(ctl_p0), .periph_select_p0(sel_p0), .pin_in_p1(pin_p1),
		.pin_out_p1(out_p1), .pin_oe_p1(oe_p1), .pull_up_p1(pu_p1),
		.pin_control_p1(ctl_p1), .periph_select_p1(sel_p1), .irq(irq));
	function [63:0] mix(input [31:0] lo, input [31:0] hi);
		integer k;
		begin
			for (k = 0; k < 32; k = k + 1)
				mix[2*k +: 2] = {hi[k], lo[k]};
		end
	endfunction
	pin_model pins (.clk(clk), .level(level), .glitch(glitch), .pin_p0(pin_p0),
		.pin_p1(pin_p1));
	function [31:0] rnd(input [31:0] s);
		reg [31:0] x;
		begin
			x = s ^ (s << 13);
			x = x ^ (x >> 17);
			rnd = x ^ (x << 5);
		end
	endfunction
	task stop_test;
		begin
			$display("Checks %0d, mismatches %0d", n_tests, err_total);
			if (err_total == 0 && n_tests > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	task chk(input [63:0] name, input [31:0] seen, input [31:0] exp);
		begin
			n_tests = n_tests + 1;
			if (seen !== exp) begin
				err_total = err_total + 1;
				$display("MISMATCH %0s expected %h seen %h", name, exp, seen);
			end
		end
	endtask
	task wr(input [8:0] a, input [31:0] d);
		begin
			@(posedge clk);
			addr <= a;
			wr_data <= d;
			wr_strobe <= 1'b1;
			@(posedge clk);
			wr_strobe <= 1'b0;
		end
	endtask
	task rc(input [8:0] a, input [31:0] e, input [63:0] name);
		begin
			@(posedge clk);
			addr <= a;
			rd_strobe <= 1'b1;
			@(posedge clk);
			rd_strobe <= 1'b0;
			@(negedge clk);
			chk(name, rd_data, e);
		end
	endtask
	// Filter is switched only while the pin's enable is off
	task ev(input p, input [4:0] k, input [1:0] m, input ie, input gf, input gl);
		reg [8:0] b;
		reg [31:0] bm;
		reg up;
		reg hit;
		begin
			b = {p, 8'h00};
			bm = 32'h1 << k;
			wr(b | 9'h090, 32'h0);
			wr(b | 9'h0C0, gf ? bm : 32'h0);
			wr(b | 9'h0A0, m[0] ? bm : 32'h0);
			wr(b | 9'h0B0, m[1] ? bm : 32'h0);
			wr(b | 9'h0D8, 32'hFFFFFFFF);
			wr(b | 9'h090, ie ? bm : 32'h0);
			up = !level[{p, k}];
			@(posedge clk);
			if (gl)
				glitch[{p, k}] <= 1'b1;
			else
				level[{p, k}] <= up;
			@(posedge clk);
			glitch <= 64'h0;
			repeat (8) @(posedge clk);
			hit = ie && m != 2'h3 && (gl ? !gf : (m == 2'h0 || m[0] == up));
			rc(b | 9'h0D0, hit ? bm : 32'h0, "flags");
			chk("irq", {31'h0, irq[{p, k[4:3]}]}, {31'h0, hit});
			wr(b | 9'h0D8, bm);
			rc(b | 9'h0D0, 32'h0, "cleared");
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			err_total = err_total + 1;
			stop_test;
		end
	end
	initial begin
		reset_n = 1'b0;
		addr = 9'h000;
		wr_data = 32'h0;
		wr_strobe = 1'b0;
		rd_strobe = 1'b0;
		level = 64'h0;
		glitch = 64'h0;
		seed = 32'hA723B778;
		err_total = 0;
		n_tests = 0;
		cyc = 0;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		rc(9'h000, 32'h0FFFFFFF, "ctl0");
		rc(9'h100, 32'h00000FFF, "ctl1");
		rc(9'h1D0, 32'h00000FFF, "flags1");
		rc(9'h190, 32'h0, "ien1");
		wr(9'h0D0, 32'h0);
		rc(9'h0D0, 32'h0FFFFFFF, "flags0");
		wr(9'h0D8, 32'hFFFFFFFF);
		wr(9'h1D8, 32'hFFFFFFFF);
		rc(9'h0D0, 32'h0, "clr0");
		rc(9'h1D0, 32'h0, "clr1");
		rc(9'h0E0, 32'h0, "unmap");
		rc(9'h0C4, 32'h0, "setaddr");
		for (i = 0; i < 6; i = i + 1) begin
			ba = {i[0], 8'h00};
			seed = rnd(seed);
			r = seed;
			wr(ba | 9'h0C0, r);
			rc(ba | 9'h0C0, r, "gf_rw");
			seed = rnd(seed);
			wr(ba | 9'h0C4, seed);
			r = r | seed;
			seed = rnd(seed);
			wr(ba | 9'h0C8, seed);
			r = r & ~seed;
			seed = rnd(seed);
			wr(ba | 9'h0CC, seed);
			r = r ^ seed;
			rc(ba | 9'h0C0, r, "gf_stct");
			wr(ba | 9'h048, 32'hFFFFFFFF);
			wr(ba | 9'h004, 32'hFFFFFFFF);
			wr(ba | 9'h010, r);
			wr(ba | 9'h020, ~seed);
			wr(ba | 9'h040, seed);
			wr(ba | 9'h050, ~r);
			wr(ba | 9'h070, r ^ seed);
			sx = mix(r, ~seed);
			rc(ba | 9'h050, ~r, "ovr");
			chk("out", i[0] ? out_p1 : out_p0, ~r);
			chk("oe", i[0] ? oe_p1 : oe_p0, seed);
			chk("pull", i[0] ? pu_p1 : pu_p0, r ^ seed);
			chk("ctl", i[0] ? ctl_p1 : ctl_p0, 32'hFFFFFFFF);
			chk("sel_lo", i[0] ? sel_p1[31:0] : sel_p0[31:0], sx[31:0]);
			chk("sel_hi", i[0] ? sel_p1[63:32] : sel_p0[63:32], sx[63:32]);
		end
		for (i = 0; i < 8; i = i + 1)
			ev(1'b0, 5'd3, i[2:1], 1'b1, 1'b0, 1'b0);
		ev(1'b0, 5'd3, 2'h0, 1'b1, 1'b1, 1'b1);
		ev(1'b0, 5'd3, 2'h0, 1'b1, 1'b0, 1'b1);
		ev(1'b0, 5'd3, 2'h0, 1'b1, 1'b1, 1'b0);
		ev(1'b0, 5'd3, 2'h0, 1'b0, 1'b0, 1'b0);
		ev(1'b1, 5'd31, 2'h1, 1'b1, 1'b0, 1'b0);
		for (i = 0; i < 16; i = i + 1) begin
			seed = rnd(seed);
			ev(seed[0], seed[5:1], seed[7:6], seed[8] | seed[9], seed[10], seed[11]);
		end
		stop_test;
	end
endmodule // testbench
